// >>> xac_pkg.sv
package xac_pkg;
	// number of chip-select spaces and pin widths
	localparam int XAC_SPACES = 4;
	localparam int XAC_ADDR_W = 4;
	localparam int XAC_DATA_W = 32;
	// widths of the per-space timing fields and of the phase counter
	localparam int XAC_SETUP_W = 4;
	localparam int XAC_STROBE_W = 6;
	localparam int XAC_HOLD_W = 3;
	localparam int XAC_CNT_W = 6;
	// ready sampling: two flops, then one cycle to release the strobe
	localparam int XAC_RDY_SYNC_STAGES = 2;
	// clock rate, kept for converting printed times
	localparam int XAC_CLK_PERIOD_NS = 40;
	// reset values of pins: all strobes and selects idle high
	localparam logic [XAC_SPACES-1:0] XAC_SEL_IDLE = 4'hF;
	localparam logic [XAC_ADDR_W-1:0] XAC_ADDR_RST = 4'h0;
	localparam logic [XAC_DATA_W-1:0] XAC_DATA_RST = 32'h0000_0000;
	// cycle phases
	typedef enum logic [3:0] {
		XAC_ST_IDLE = 4'b0001,
		XAC_ST_SETUP = 4'b0010,
		XAC_ST_STROBE = 4'b0100,
		XAC_ST_HOLD = 4'b1000
	} xac_state_t;
endpackage

// >>> xac_async_cycle.sv
// What this block does
// - read strobe low exactly read strobe count
// - selects valid read setup count before strobe
// - selects held read hold count after strobe
// - selects and data valid write setup count
// - selects and data held write hold count
// - write strobe low exactly write strobe count
// - read strobe releases 3-4 cycles after ready
// - write strobe releases 3-4 cycles after ready
// - ready synchronised internally, asynchronous input allowed
// - chip select may linger seven cycles
// - selects include address, output enable, write data
// - ready is active high, peripheral driven
// - shared pins carry word address five:two
// - shared pin is active-low write strobe
// - six counts per space, in clock periods
`timescale 1ns/1ps
module xac_async_cycle
	import xac_pkg::*;
#(
	parameter int SPACES = XAC_SPACES
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// access request
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic req_use_ready_i,
	input wire logic [1:0] req_space_i,
	input wire logic [XAC_ADDR_W-1:0] req_addr_i,
	input wire logic [XAC_DATA_W-1:0] req_data_i,
	output logic req_ready_o,
	output logic done_o,
	output logic [XAC_DATA_W-1:0] rd_data_o,
	// per-space timing counts
	input wire logic [SPACES-1:0][XAC_SETUP_W-1:0] read_setup_count_i,
	input wire logic [SPACES-1:0][XAC_STROBE_W-1:0] read_strobe_count_i,
	input wire logic [SPACES-1:0][XAC_HOLD_W-1:0] read_hold_count_i,
	input wire logic [SPACES-1:0][XAC_SETUP_W-1:0] write_setup_count_i,
	input wire logic [SPACES-1:0][XAC_STROBE_W-1:0] write_pulse_count_i,
	input wire logic [SPACES-1:0][XAC_HOLD_W-1:0] write_hold_count_i,
	// expansion bus pins
	input wire logic peripheral_ready_i,
	input wire logic [XAC_DATA_W-1:0] bus_data_i,
	output logic [XAC_DATA_W-1:0] bus_data_o,
	output logic bus_data_oe_o,
	output logic [SPACES-1:0] space_select_n_o,
	output logic [XAC_ADDR_W-1:0] byte_enable_or_word_addr_o,
	output logic output_enable_n_o,
	output logic read_strobe_n_o,
	output logic write_strobe_or_wait_n_o
);

	// a zero count still lasts one clock; returns cycles minus one
	function automatic logic [XAC_CNT_W-1:0] xac_last(input logic [XAC_CNT_W-1:0] c);
		xac_last = (c == '0) ? '0 : c - 1'b1;
	endfunction

	xac_state_t state;
	xac_state_t next_state;
	logic [XAC_CNT_W-1:0] cnt;
	logic [XAC_CNT_W-1:0] next_cnt;
	logic cur_write;
	logic cur_use_ready;
	logic [1:0] cur_space;
	logic [XAC_CNT_W-1:0] cur_setup;
	logic [XAC_CNT_W-1:0] cur_strobe;
	logic [XAC_CNT_W-1:0] cur_hold;
	logic [XAC_ADDR_W-1:0] cur_addr;
	logic [XAC_DATA_W-1:0] cur_data;
	logic rdy_meta;
	logic rdy_sync;
	logic rdy_seen;

	// two-flop synchroniser for the asynchronous ready pin, then one more stage
	// so that the strobe lets go three to four clocks after the pin rises
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rdy_meta <= 1'b0;
			rdy_sync <= 1'b0;
			rdy_seen <= 1'b0;
		end
		else
		begin
			rdy_meta <= peripheral_ready_i;
			rdy_sync <= rdy_meta;
			rdy_seen <= rdy_sync;
		end
	end

	// request acceptance and count lookup for the requested space
	wire accept = req_valid_i && (state == XAC_ST_IDLE);
	wire [XAC_CNT_W-1:0] pick_setup = req_write_i ?
		XAC_CNT_W'(write_setup_count_i[req_space_i]) :
		XAC_CNT_W'(read_setup_count_i[req_space_i]);
	wire [XAC_CNT_W-1:0] pick_strobe = req_write_i ?
		XAC_CNT_W'(write_pulse_count_i[req_space_i]) :
		XAC_CNT_W'(read_strobe_count_i[req_space_i]);
	wire [XAC_CNT_W-1:0] pick_hold = req_write_i ?
		XAC_CNT_W'(write_hold_count_i[req_space_i]) :
		XAC_CNT_W'(read_hold_count_i[req_space_i]);
	wire cnt_done = (cnt == '0);
	// strobe may end only once its count is spent and, if asked, ready is high
	wire strobe_end = cnt_done && (!cur_use_ready || rdy_seen);

	// phase sequencing and phase counter
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			XAC_ST_IDLE:
			begin
				if (accept)
				begin
					next_state = XAC_ST_SETUP;
					next_cnt = xac_last(pick_setup);
				end
			end
			XAC_ST_SETUP:
			begin
				if (cnt_done)
				begin
					next_state = XAC_ST_STROBE;
					next_cnt = xac_last(cur_strobe);
				end
				else
					next_cnt = cnt - 1'b1;
			end
			XAC_ST_STROBE:
			begin
				if (strobe_end)
				begin
					next_state = XAC_ST_HOLD;
					next_cnt = xac_last(cur_hold);
				end
				else if (!cnt_done)
					next_cnt = cnt - 1'b1;
			end
			XAC_ST_HOLD:
			begin
				if (cnt_done)
					next_state = XAC_ST_IDLE;
				else
					next_cnt = cnt - 1'b1;
			end
			default:
			begin
				next_state = XAC_ST_IDLE;
				next_cnt = '0;
			end
		endcase
	end

	// pin values for the next cycle, derived from the next phase
	wire next_write = accept ? req_write_i : cur_write;
	wire [1:0] next_space = accept ? req_space_i : cur_space;
	wire [XAC_ADDR_W-1:0] next_addr = accept ? req_addr_i : cur_addr;
	wire [XAC_DATA_W-1:0] next_data = accept ? req_data_i : cur_data;
	wire next_active = (next_state != XAC_ST_IDLE);
	wire next_strobe = (next_state == XAC_ST_STROBE);
	wire [SPACES-1:0] next_sel_n = next_active ?
		~(SPACES'(1) << next_space) : XAC_SEL_IDLE;

	// phase state and latched request
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state <= XAC_ST_IDLE;
			cnt <= '0;
			cur_write <= 1'b0;
			cur_use_ready <= 1'b0;
			cur_space <= 2'h0;
			cur_setup <= '0;
			cur_strobe <= '0;
			cur_hold <= '0;
			cur_addr <= XAC_ADDR_RST;
			cur_data <= XAC_DATA_RST;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			if (accept)
			begin
				cur_write <= req_write_i;
				cur_use_ready <= req_use_ready_i;
				cur_space <= req_space_i;
				cur_setup <= pick_setup;
				cur_strobe <= pick_strobe;
				cur_hold <= pick_hold;
				cur_addr <= req_addr_i;
				cur_data <= req_data_i;
			end
		end
	end

	// registered pins; selects span setup, strobe and hold unchanged
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			space_select_n_o <= XAC_SEL_IDLE;
			byte_enable_or_word_addr_o <= XAC_ADDR_RST;
			output_enable_n_o <= 1'b1;
			read_strobe_n_o <= 1'b1;
			write_strobe_or_wait_n_o <= 1'b1;
			bus_data_o <= XAC_DATA_RST;
			bus_data_oe_o <= 1'b0;
		end
		else
		begin
			space_select_n_o <= next_sel_n;
			byte_enable_or_word_addr_o <= next_addr;
			output_enable_n_o <= !(next_active && !next_write);
			read_strobe_n_o <= !(next_strobe && !next_write);
			write_strobe_or_wait_n_o <= !(next_strobe && next_write);
			bus_data_o <= next_data;
			bus_data_oe_o <= next_active && next_write;
		end
	end

	// handshake outputs and read data capture at the strobe's last cycle
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			req_ready_o <= 1'b1;
			done_o <= 1'b0;
			rd_data_o <= XAC_DATA_RST;
		end
		else
		begin
			req_ready_o <= (next_state == XAC_ST_IDLE);
			done_o <= (state == XAC_ST_HOLD) && cnt_done;
			if ((state == XAC_ST_STROBE) && strobe_end && !cur_write)
				rd_data_o <= bus_data_i;
		end
	end

	// helper counters for checking phase lengths at the pins
	logic [7:0] low_len;
	logic [7:0] pre_len;
	logic [7:0] post_len;
	logic after_stb;
	wire any_strobe = !read_strobe_n_o || !write_strobe_or_wait_n_o;
	wire any_sel = (space_select_n_o != XAC_SEL_IDLE);
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			low_len <= 8'h00;
			pre_len <= 8'h00;
			post_len <= 8'h00;
			after_stb <= 1'b0;
		end
		else
		begin
			low_len <= any_strobe ? low_len + 8'h01 : 8'h00;
			// a strobe splits the select window into its setup and hold parts
			after_stb <= any_strobe || (any_sel && after_stb);
			pre_len <= (any_sel && !any_strobe && !after_stb) ? pre_len + 8'h01 : 8'h00;
			post_len <= (any_sel && !any_strobe && after_stb) ? post_len + 8'h01 : 8'h00;
		end
	end
	wire [7:0] eff_strobe = (cur_strobe == '0) ? 8'h01 : 8'(cur_strobe);
	wire [7:0] eff_setup = (cur_setup == '0) ? 8'h01 : 8'(cur_setup);
	wire [7:0] eff_hold = (cur_hold == '0) ? 8'h01 : 8'(cur_hold);

	AST_RD_STROBE_WIDTH: assert property (@(posedge clk_i) disable iff (reset_i)
		($rose(read_strobe_n_o) && !cur_use_ready) |-> (low_len == eff_strobe))
		else $error("read strobe width differs from programmed count");

	AST_WR_STROBE_WIDTH: assert property (@(posedge clk_i) disable iff (reset_i)
		($rose(write_strobe_or_wait_n_o) && !cur_use_ready) |-> (low_len == eff_strobe))
		else $error("write strobe width differs from programmed count");

	AST_RD_SETUP: assert property (@(posedge clk_i) disable iff (reset_i)
		$fell(read_strobe_n_o) |-> (pre_len == eff_setup))
		else $error("read setup length wrong");

	AST_WR_SETUP: assert property (@(posedge clk_i) disable iff (reset_i)
		$fell(write_strobe_or_wait_n_o) |-> (pre_len == eff_setup) && bus_data_oe_o)
		else $error("write setup length wrong or data not driven");

	AST_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
		$fell(any_sel) |-> (post_len == eff_hold))
		else $error("hold length wrong");

	AST_RD_READY_RELEASE: assert property (@(posedge clk_i) disable iff (reset_i)
		(!read_strobe_n_o && cur_use_ready && cnt_done && state == XAC_ST_STROBE
		&& $rose(peripheral_ready_i)) |-> ##[3:4] $rose(read_strobe_n_o))
		else $error("read strobe not released after ready");

	AST_WR_READY_RELEASE: assert property (@(posedge clk_i) disable iff (reset_i)
		(!write_strobe_or_wait_n_o && cur_use_ready && cnt_done && state == XAC_ST_STROBE
		&& $rose(peripheral_ready_i)) |-> ##[3:4] $rose(write_strobe_or_wait_n_o))
		else $error("write strobe not released after ready");

	AST_SELECT_STABLE: assert property (@(posedge clk_i) disable iff (reset_i)
		($past(any_sel) && any_sel) |-> ($stable(byte_enable_or_word_addr_o)
		&& $stable(space_select_n_o) && $stable(output_enable_n_o) && $stable(bus_data_o)))
		else $error("select signals changed within a cycle");

	AST_STROBE_IN_SELECT: assert property (@(posedge clk_i) disable iff (reset_i)
		any_strobe |-> (any_sel && (read_strobe_n_o || write_strobe_or_wait_n_o)))
		else $error("strobe outside select or both strobes low");

	AST_READY_SYNC: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(rdy_sync) |-> $past(peripheral_ready_i, 2))
		else $error("ready seen without two-flop delay");

	AST_DONE_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (reset_i)
		done_o |=> !done_o)
		else $error("done pulse longer than one cycle");

	AST_ONE_SPACE: assert property (@(posedge clk_i) disable iff (reset_i)
		any_sel |-> $onehot(~space_select_n_o))
		else $error("more than one space selected");

	AST_READY_STRETCH: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == XAC_ST_STROBE && cnt_done && cur_use_ready && !rdy_seen)
		|=> (state == XAC_ST_STROBE))
		else $error("strobe ended while ready was low");

	AST_READ_NO_DRIVE: assert property (@(posedge clk_i) disable iff (reset_i)
		!output_enable_n_o |-> (!bus_data_oe_o && write_strobe_or_wait_n_o))
		else $error("data driven or write strobe low during a read");

	AST_IDLE_WHEN_READY: assert property (@(posedge clk_i) disable iff (reset_i)
		req_ready_o |-> (!any_sel && !any_strobe))
		else $error("request ready while a cycle is on the bus");

endmodule

// >>> xac_periph_model.sv
`timescale 1ns/1ps
module xac_periph_model
	import xac_pkg::*;
(
	// clock and pins seen by the peripheral
	input wire logic clk_i,
	input wire logic [XAC_SPACES-1:0] sel_n_i,
	input wire logic oe_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	// word to return and strobe cycles to stall
	input wire logic [XAC_DATA_W-1:0] word_i,
	input wire logic [3:0] stall_i,
	// driven back to the block
	output logic [XAC_DATA_W-1:0] bus_data_o,
	output logic peripheral_ready_o
);
	logic [XAC_DATA_W-1:0] last = 32'h0;
	logic [3:0] held = 4'h0;
	wire logic idle = sel_n_i == XAC_SEL_IDLE;
	wire logic drive = !idle && !oe_n_i;
	// released lines toggle so a stale word never passes
	assign bus_data_o = drive ? word_i : last;
	// ready low from select until the stall runs out, then high until deselect
	assign peripheral_ready_o = idle || held >= stall_i;
	// strobe cycles counted per access
	always @(posedge clk_i)
	begin
		last <= drive ? word_i : ~last;
		held <= idle ? 4'h0 : held + {3'h0, !rd_n_i || !wr_n_i};
	end
endmodule

// >>> tb_xac_async_cycle.sv
`timescale 1ns/1ps
module tb_xac_async_cycle
	import xac_pkg::*;
;
	// stimulus and pins
	logic clk_i = 0, reset_i = 1, req_valid_i = 0, req_write_i = 0, req_use_ready_i = 0;
	logic [1:0] req_space_i = 2'h0;
	logic [3:0] req_addr_i = 4'h0, stall = 4'h0;
	logic [31:0] req_data_i = 32'h0, rd_data_o, bus_data_i, bus_data_o;
	logic req_ready_o, done_o, bus_data_oe_o, output_enable_n_o, read_strobe_n_o;
	logic write_strobe_or_wait_n_o, peripheral_ready_i, w;
	logic [3:0] space_select_n_o, byte_enable_or_word_addr_o;
	logic [1:0] sp;
	// per-space counts, space 3 first; space 0 read counts sum to five
	logic [3:0][3:0] read_setup_count_i = {4'h3, 4'h0, 4'h2, 4'h1};
	logic [3:0][3:0] write_setup_count_i = {4'h3, 4'h1, 4'h0, 4'h2};
	logic [3:0][5:0] read_strobe_count_i = {6'h02, 6'h04, 6'h01, 6'h03};
	logic [3:0][5:0] write_pulse_count_i = {6'h01, 6'h03, 6'h05, 6'h02};
	logic [3:0][2:0] read_hold_count_i = {3'h7, 3'h0, 3'h2, 3'h1};
	logic [3:0][2:0] write_hold_count_i = {3'h2, 3'h1, 3'h0, 3'h3};
	logic [39:0] cur = 40'h0;
	logic seen = 0, pr = 1, ps = 0;
	int cyc = 0, ns, nt, nh, t_rdy, t_rel, bad, errors = 0, total_checks = 0;
	wire logic act = space_select_n_o != 4'hF;
	wire logic stb = !read_strobe_n_o || !write_strobe_or_wait_n_o;
	// rows: {write, use ready, space, word address, data}
	logic [39:0] rows [9] = '{40'h05A5A50001, 40'h9A12345678, 40'h23C3C3C3C3,
		40'hBF0F0F0F0F, 40'h3E89ABCDEF, 40'h8600FF00FF, 40'h4755AA55AA,
		40'hE1FFFF0000, 40'h1C13579BDF};
	xac_async_cycle DUT (.clk_i, .reset_i, .req_valid_i, .req_write_i, .req_use_ready_i,
		.req_space_i, .req_addr_i, .req_data_i, .req_ready_o, .done_o, .rd_data_o,
		.read_setup_count_i, .read_strobe_count_i, .read_hold_count_i, .write_setup_count_i,
		.write_pulse_count_i, .write_hold_count_i, .peripheral_ready_i, .bus_data_i,
		.bus_data_o, .bus_data_oe_o, .space_select_n_o, .byte_enable_or_word_addr_o,
		.output_enable_n_o, .read_strobe_n_o, .write_strobe_or_wait_n_o);
	xac_periph_model peer (.clk_i, .sel_n_i(space_select_n_o), .oe_n_i(output_enable_n_o),
		.rd_n_i(read_strobe_n_o), .wr_n_i(write_strobe_or_wait_n_o), .word_i(cur[31:0]),
		.stall_i(stall), .bus_data_o(bus_data_i), .peripheral_ready_o(peripheral_ready_i));
	always #20 clk_i = ~clk_i;
	// phase counts, ready latency, select stability, timeout
	always @(posedge clk_i)
	begin
		cyc++;
		if (stb)
		begin
			nt++;
			seen = 1;
		end
		else if (act && !seen) ns++;
		else if (act) nh++;
		if (peripheral_ready_i && !pr) t_rdy = cyc;
		if (ps && !stb) t_rel = cyc;
		pr = peripheral_ready_i;
		ps = stb;
		if (act && (space_select_n_o !== ~(4'h1 << cur[37:36])
			|| byte_enable_or_word_addr_o !== cur[35:32] || output_enable_n_o !== cur[39]
			|| bus_data_oe_o !== cur[39] || (cur[39] && bus_data_o !== cur[31:0])
			|| (cur[39] ? !read_strobe_n_o : !write_strobe_or_wait_n_o))) bad++;
		if (cyc == 5000)
		begin
			errors++;
			finish_test();
		end
	end
	function automatic int eff(input int x);
		return (x == 0) ? 1 : x;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one access, request held until taken, bounded wait for done
	task automatic access(input logic [39:0] r);
		int n;
		@(posedge clk_i) #1;
		cur = r;
		stall = r[38] ? 4'h5 : 4'h0;
		n = 0;
		seen = 0;
		{ns, nt, nh, bad, t_rdy, t_rel} = '0;
		{req_valid_i, req_write_i, req_use_ready_i, req_space_i, req_addr_i, req_data_i} = {1'b1, r};
		@(posedge clk_i);
		while (req_ready_o !== 1'b1 && n++ < 20) @(posedge clk_i);
		#1 req_valid_i = 0;
		n = 0;
		while (done_o !== 1'b1 && n++ < 200) @(posedge clk_i) #1;
		check({31'h0, done_o}, 32'h1);
	endtask
	initial
	begin
		repeat (4) @(posedge clk_i);
		#1 reset_i = 0;
		check(32'({req_ready_o, space_select_n_o, read_strobe_n_o, write_strobe_or_wait_n_o}),
			32'h7F);
		for (int i = 0; i < 9; i++)
		begin
			access(rows[i]);
			w = rows[i][39];
			sp = rows[i][37:36];
			check(32'(ns), 32'(eff(w ? write_setup_count_i[sp] : read_setup_count_i[sp])));
			if (rows[i][38])
				check(32'((t_rel - t_rdy) inside {3, 4}), 32'h1);
			else
				check(32'(nt), 32'(eff(w ? write_pulse_count_i[sp] : read_strobe_count_i[sp])));
			check(32'(nh), 32'(eff(w ? write_hold_count_i[sp] : read_hold_count_i[sp])));
			check(32'(bad), 32'h0);
			if (!w) check(rd_data_o, rows[i][31:0]);
			$display("row %0d done", i);
		end
		// reset in mid-cycle returns the pins to idle
		@(posedge clk_i) #1;
		{req_valid_i, req_write_i, req_use_ready_i, req_space_i, req_addr_i, req_data_i} = {1'b1, rows[4]};
		repeat (5) @(posedge clk_i);
		#1 reset_i = 1;
		req_valid_i = 0;
		#1 check(32'({req_ready_o, space_select_n_o, read_strobe_n_o, done_o}), 32'h7E);
		@(posedge clk_i) #1 reset_i = 0;
		access(rows[0]);
		check(32'(ns + nt + nh), 32'h5);
		check(rd_data_o, rows[0][31:0]);
		$display("reset test done");
		finish_test();
	end
endmodule
